// *** hdl/ctc_top.sv ***
// Commissioning test control: monitor selectors, contact test, lamp test,
// test mode and reclose test start.
// Assumes inputs synchronous to sys_clk and a one-cycle-strobe register port.
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
// Operation
// - Logic inputs read back as a vector, one means energised.
// - Output relay drive signals read back as a vector, one means operated.
// - In test mode the output vector still shows in-service logic drive.
// - Monitor status has eight bits, each the selected bus signal.
// - Eight-bit indicator vector, one while each indicator is lit.
// - Each monitor selector takes a bus index 0 to 511.
// - Each selected monitor signal also drives its own monitor pin.
// - Test mode is off, test or blocked; test raises alarm and indicator.
// - Test mode freezes breaker wear data and marks transmission cause test.
// - Test keeps contacts live, blocked inhibits them, off or test restores them.
// - An energised input mapped to test mode also enters test mode.
// - Test pattern holds one bit per contact, one inverts its drive while forced.
// - Apply-test forces patterned contacts, then the command returns to nop.
// - Forced contacts hold until remove-test, then the command returns to nop.
// - Lamp check lights all eight indicators for two seconds, then nop.
// - Reclose trip test runs one trip and reclose cycle per command.
// - Command returns to nop once the trip output has operated.
module ctc_top #(
  parameter int NUM_IN = 16,
  parameter int NUM_OUT = 16,
  parameter int LAMP_CYCLES = ctc_pkg::LAMP_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  input wire logic [NUM_IN-1:0] opto_in,
  input wire logic test_mode_in,
  input wire logic [511:0] internal_signal_bus,
  input wire logic [NUM_OUT-1:0] relay_drive,
  input wire logic [ctc_pkg::NUM_LED-1:0] led_drive,
  input wire logic reclose_present,
  output logic [NUM_OUT-1:0] contact_out,
  output logic [ctc_pkg::NUM_LED-1:0] indicator_out,
  output logic [ctc_pkg::NUM_MON-1:0] monitor_pin,
  output logic service_off_indicator,
  output logic test_alarm,
  output logic protection_service_off_indicator,
  output logic breaker_wear_freeze,
  output logic transmission_cause_test,
  output logic reclose_check_trip_signal
);
  localparam int NM = ctc_pkg::NUM_MON;
  localparam int LCW = $clog2(LAMP_CYCLES + 1);

  ctc_pkg::ctc_bus_req_t req;
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  logic [ctc_pkg::SEL_W-1:0] mon_sel [NM];
  ctc_pkg::ctc_mode_t mode_cell;
  logic [NUM_OUT-1:0] pattern;
  logic forced;
  logic lamp_on;
  logic [LCW-1:0] lamp_cnt;
  logic reclose_cmd;
  logic [ctc_pkg::IRQ_W-1:0] irq_status;
  logic [ctc_pkg::IRQ_W-1:0] irq_mask;
  logic test_prev;

  // Address decode.
  wire wr_mode = req.wr && req.addr == ctc_pkg::REG_TEST_MODE;
  wire wr_pat = req.wr && req.addr == ctc_pkg::REG_PATTERN;
  wire wr_ct = req.wr && req.addr == ctc_pkg::REG_CONTACT_CMD;
  wire wr_lamp = req.wr && req.addr == ctc_pkg::REG_LAMP_CMD;
  wire wr_rcl = req.wr && req.addr == ctc_pkg::REG_RECLOSE_CMD;
  wire wr_ist = req.wr && req.addr == ctc_pkg::REG_IRQ_STATUS;
  wire wr_imask = req.wr && req.addr == ctc_pkg::REG_IRQ_MASK;
  wire [1:0] ct_code = req.wdata[1:0];
  wire apply_cmd = wr_ct && ct_code == ctc_pkg::CTC_CT_APPLY;
  wire remove_cmd = wr_ct && ct_code == ctc_pkg::CTC_CT_REMOVE;
  wire lamp_start = wr_lamp && req.wdata[0] && !lamp_on;

  // Effective mode: control cell or mapped input.
  wire mode_test = mode_cell != ctc_pkg::CTC_MODE_OFF || test_mode_in;
  wire mode_blocked = mode_cell == ctc_pkg::CTC_MODE_BLOCKED;

  // Monitor selection.
  logic [NM-1:0] mon_val;
  genvar g;
  generate
    for (g = 0; g < NM; g++)
    begin : g_mon
      assign mon_val[g] = internal_signal_bus[mon_sel[g]];
    end
  endgenerate

  // Contact path: pattern forcing changes state of patterned contacts.
  wire [NUM_OUT-1:0] forced_val = relay_drive ^ pattern;
  wire [NUM_OUT-1:0] service_val = forced ? forced_val : relay_drive;
  wire [NUM_OUT-1:0] next_contact =
    mode_blocked ? '0 : service_val;
  wire [ctc_pkg::NUM_LED-1:0] next_indicator =
    lamp_on ? '1 : led_drive;
  wire trip_seen = reclose_cmd && relay_drive[ctc_pkg::RECLOSE_TRIP_RELAY-1];
  wire [ctc_pkg::IRQ_W-1:0] irq_set = {trip_seen,
    lamp_on && lamp_cnt == LCW'(1), mode_test && !test_prev};

  // Read mux.
  wire [3:0] sel_idx = 4'((req.addr - ctc_pkg::REG_MON_SEL0) >> 2);
  wire in_sel = req.addr >= ctc_pkg::REG_MON_SEL0 &&
    req.addr < ctc_pkg::REG_TEST_MODE && req.addr[1:0] == 2'b00;
  logic [31:0] next_rdata;
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (in_sel)
      next_rdata = 32'(mon_sel[sel_idx[2:0]]);
    else
      unique case (req.addr)
        ctc_pkg::REG_INPUTS: next_rdata = 32'(opto_in);
        ctc_pkg::REG_OUTPUTS: next_rdata = 32'(relay_drive);
        ctc_pkg::REG_MON_STATUS: next_rdata = 32'(mon_val);
        ctc_pkg::REG_INDICATOR_STATE_VECTOR: next_rdata = 32'(indicator_out);
        ctc_pkg::REG_TEST_MODE: next_rdata = 32'(mode_cell);
        ctc_pkg::REG_PATTERN: next_rdata = 32'(pattern);
        ctc_pkg::REG_CONTACT_CMD: next_rdata = 32'h0000_0000;
        ctc_pkg::REG_LAMP_CMD: next_rdata = 32'(lamp_on);
        ctc_pkg::REG_RECLOSE_CMD: next_rdata = 32'(reclose_cmd);
        ctc_pkg::REG_IRQ_STATUS: next_rdata = 32'(irq_status);
        ctc_pkg::REG_IRQ_MASK: next_rdata = 32'(irq_mask);
        default: next_rdata = 32'h0000_0000;
      endcase
  end

  // Configuration registers.
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < NM; i++)
        mon_sel[i] <= ctc_pkg::SEL_W'(ctc_pkg::MON_DEFAULT_BASE + i);
      mode_cell <= ctc_pkg::CTC_MODE_OFF;
      pattern <= NUM_OUT'(ctc_pkg::PATTERN_RESET);
      irq_mask <= '0;
    end
    else
    begin
      for (int i = 0; i < NM; i++)
        if (req.wr && req.addr == 8'(ctc_pkg::REG_MON_SEL0 + 4 * i))
          mon_sel[i] <= req.wdata[ctc_pkg::SEL_W-1:0];
      if (wr_mode && req.wdata[1:0] != 2'b11)
        mode_cell <= ctc_pkg::ctc_mode_t'(req.wdata[1:0]);
      if (wr_pat)
        pattern <= req.wdata[NUM_OUT-1:0];
      if (wr_imask)
        irq_mask <= req.wdata[ctc_pkg::IRQ_W-1:0];
    end
  end

  // Test commands; command cells read back as no-operation after acting.
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      forced <= 1'b0;
      lamp_on <= 1'b0;
      lamp_cnt <= '0;
      reclose_cmd <= 1'b0;
    end
    else
    begin
      if (apply_cmd)
        forced <= 1'b1;
      else if (remove_cmd)
        forced <= 1'b0;
      if (lamp_start)
      begin
        lamp_on <= 1'b1;
        lamp_cnt <= LCW'(LAMP_CYCLES);
      end
      else if (lamp_on)
      begin
        lamp_cnt <= lamp_cnt - LCW'(1);
        if (lamp_cnt == LCW'(1))
          lamp_on <= 1'b0;
      end
      // A repeated command starts the next cycle of the sequence.
      if (wr_rcl && req.wdata[0] && reclose_present)
        reclose_cmd <= 1'b1;
      else if (trip_seen)
        reclose_cmd <= 1'b0;
    end
  end

  // Interrupts: set wins over a write-one clear in the same cycle.
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      irq_status <= '0;
      test_prev <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      test_prev <= mode_test;
      irq_status <= (irq_status &
        ~(wr_ist ? req.wdata[ctc_pkg::IRQ_W-1:0] : '0)) | irq_set;
      irq <= |(irq_status & irq_mask);
    end
  end

  // Registered outputs.
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      reg_rdata <= 32'h0000_0000;
      contact_out <= '0;
      indicator_out <= '0;
      monitor_pin <= '0;
      service_off_indicator <= 1'b0;
      test_alarm <= 1'b0;
      protection_service_off_indicator <= 1'b0;
      breaker_wear_freeze <= 1'b0;
      transmission_cause_test <= 1'b0;
      reclose_check_trip_signal <= 1'b0;
    end
    else
    begin
      reg_rdata <= req.rd ? next_rdata : 32'h0000_0000;
      contact_out <= next_contact;
      indicator_out <= next_indicator;
      monitor_pin <= mon_val;
      service_off_indicator <= mode_test;
      test_alarm <= mode_test;
      protection_service_off_indicator <= mode_test;
      breaker_wear_freeze <= mode_test;
      transmission_cause_test <= mode_test;
      reclose_check_trip_signal <= reclose_cmd;
    end
  end
endmodule // ctc_top

// *** hdl/ctc_pkg.sv ***
// Package for the commissioning test control block.
// Assumes a single 125 MHz system clock and a plain register port.
package ctc_pkg;
  localparam int CLK_HZ = 125_000_000;
  localparam int LAMP_TIME_MS = 2000;
  localparam int LAMP_CYCLES = CLK_HZ / 1000 * LAMP_TIME_MS;
  localparam int NUM_MON = 8;
  localparam int SEL_W = 9;
  localparam int NUM_LED = 8;
  localparam int MON_DEFAULT_BASE = 64;
  // Register offsets (byte addresses).
  localparam logic [7:0] REG_INPUTS = 8'h00;
  localparam logic [7:0] REG_OUTPUTS = 8'h04;
  localparam logic [7:0] REG_MON_STATUS = 8'h08;
  localparam logic [7:0] REG_INDICATOR_STATE_VECTOR = 8'h0c;
  localparam logic [7:0] REG_MON_SEL0 = 8'h10;
  localparam logic [7:0] REG_TEST_MODE = 8'h30;
  localparam logic [7:0] REG_PATTERN = 8'h34;
  localparam logic [7:0] REG_CONTACT_CMD = 8'h38;
  localparam logic [7:0] REG_LAMP_CMD = 8'h3c;
  localparam logic [7:0] REG_RECLOSE_CMD = 8'h40;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h44;
  localparam logic [7:0] REG_IRQ_MASK = 8'h48;
  localparam logic [31:0] PATTERN_RESET = 32'h0000_0000;
  // Interrupt status bit positions.
  localparam int IRQ_TEST_ENTER = 0;
  localparam int IRQ_LAMP_DONE = 1;
  localparam int IRQ_RECLOSE_TRIP = 2;
  localparam int IRQ_W = 3;
  localparam int RECLOSE_TRIP_RELAY = 3;

  typedef enum logic [1:0] {
    CTC_MODE_OFF = 2'b00,
    CTC_MODE_TEST = 2'b01,
    CTC_MODE_BLOCKED = 2'b10
  } ctc_mode_t;

  typedef enum logic [1:0] {
    CTC_CT_NOP = 2'b00,
    CTC_CT_APPLY = 2'b01,
    CTC_CT_REMOVE = 2'b10
  } ctc_contact_cmd_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ctc_bus_req_t;
endpackage

// *** dv/ctc_checker.sv ***
// Port-level checker for ctc_top, bound into every instance.
// Assumes reg_rd stays low while rstn is low.
`timescale 1ns/1ps
module ctc_checker #(
  parameter int NUM_IN = 16,
  parameter int NUM_OUT = 16
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [NUM_IN-1:0] opto_in,
  input wire logic test_mode_in,
  input wire logic [NUM_OUT-1:0] relay_drive,
  input wire logic reclose_present,
  input wire logic [NUM_OUT-1:0] contact_out,
  input wire logic [7:0] indicator_out,
  input wire logic service_off_indicator,
  input wire logic test_alarm,
  input wire logic breaker_wear_freeze,
  input wire logic reclose_check_trip_signal
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  a_inputs_read: assert property (
    $past(reg_rd && reg_addr == ctc_pkg::REG_INPUTS)
    |-> reg_rdata == 32'($past(opto_in))) else $error("input read bad");
  a_drive_read: assert property (
    $past(reg_rd && reg_addr == ctc_pkg::REG_OUTPUTS)
    |-> reg_rdata == 32'($past(relay_drive))) else $error("drive read bad");
  a_alarm_rises: assert property (
    $rose(service_off_indicator) |-> test_alarm) else $error("no alarm");
  a_freeze_tie: assert property (
    breaker_wear_freeze == service_off_indicator) else $error("no freeze");
  a_input_enters: assert property (
    test_mode_in [*3] |-> service_off_indicator) else $error("no test mode");
  a_lamp_lights: assert property (
    reg_wr && reg_addr == ctc_pkg::REG_LAMP_CMD && reg_wdata[0]
    && indicator_out != 8'hff |-> ##3 indicator_out == 8'hff)
    else $error("lamp not lit");
  a_trip_starts: assert property (
    reg_wr && reg_addr == ctc_pkg::REG_RECLOSE_CMD && reg_wdata[0]
    && reclose_present && !relay_drive[2]
    |-> ##[1:2] reclose_check_trip_signal) else $error("no trip test");
  a_trip_clears: assert property (
    reclose_check_trip_signal && relay_drive[2]
    |-> ##[1:2] !reclose_check_trip_signal) else $error("trip held");
  a_reset_quiet: assert property (
    $rose(rstn) |-> contact_out == '0 && indicator_out == '0)
    else $error("outputs busy after reset");
endmodule // ctc_checker

bind ctc_top ctc_checker #(.NUM_IN(NUM_IN), .NUM_OUT(NUM_OUT)) u_ctc_chk (
  .sys_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .opto_in, .test_mode_in, .relay_drive, .reclose_present, .contact_out,
  .indicator_out, .service_off_indicator, .test_alarm, .breaker_wear_freeze,
  .reclose_check_trip_signal);

// *** dv/ctc_far_side.sv ***
// Far-side model: scheme mapping of the reclose trip-test onto relay 3.
// Assumes the bench chooses a short or a long answer delay.
`timescale 1ns/1ps
module ctc_far_side (
  input wire logic sys_clk,
  input wire logic [2:0] dly,
  input wire logic trip_req,
  output logic trip_relay
);
  logic [7:0] pipe = 8'h00;
  always @(posedge sys_clk) pipe <= {pipe[6:0], trip_req};
  // Relay 3 follows the trip-test signal dly + 1 cycles late.
  assign trip_relay = pipe[dly];
endmodule // ctc_far_side

// *** dv/tb_top.sv ***
// Self-checking bench for ctc_top with a far-side trip model.
// Assumes the package and the checker are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR %0t: got %h want %h", $time, g, e); end end
module tb_top;
  logic sys_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, led_drive = 8'h00, exp_mon, indicator_out;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, pat, exp_v;
  logic [15:0] opto_in = 16'h0000, logic_drive = 16'h0000, contact_out;
  logic [511:0] sig_bus = '0;
  logic test_mode_in = 1'b0, reclose_present = 1'b0, rd_q = 1'b0;
  logic irq, svc_off, trip_sig, trip_relay, alarm, oos, frz, cot_test;
  logic [2:0] dly = 3'h0;
  logic [8:0] sel;
  logic [7:0] monitor_pin;
  logic [31:0] seed = 32'h0000_0ff3;
  logic [31:0] exp_q[$];
  int n_fail = 0, n_compared = 0, n_trip = 0;
  wire [15:0] relay_drive = {logic_drive[15:3], trip_relay, logic_drive[1:0]};
  ctc_top #(.LAMP_CYCLES(20)) dut (.sys_clk, .rstn, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .irq, .opto_in, .test_mode_in,
    .internal_signal_bus(sig_bus), .relay_drive, .led_drive, .reclose_present,
    .contact_out, .indicator_out, .monitor_pin, .service_off_indicator(svc_off),
    .test_alarm(alarm), .protection_service_off_indicator(oos),
    .breaker_wear_freeze(frz), .transmission_cause_test(cot_test),
    .reclose_check_trip_signal(trip_sig));
  ctc_far_side u_far (.sys_clk, .dly, .trip_req(trip_sig), .trip_relay);
  always #4 sys_clk = ~sys_clk;
  always @(posedge trip_relay) n_trip++;
  always @(posedge sys_clk) rd_q <= reg_rd;
  // Read data stands only in the cycle after the strobe, so check mid-cycle.
  always @(negedge sys_clk)
    if (rd_q && exp_q.size() > 0)
    begin
      exp_v = exp_q.pop_front();
      `CHK(reg_rdata, exp_v)
    end
  function logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    exp_q.push_back(e);
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask
  task automatic settle();
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task automatic close_out();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    close_out();
  end
  initial
  begin
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 16; i++) sig_bus[i*32 +: 32] <= rnd();
    opto_in <= 16'(rnd());
    logic_drive <= 16'(rnd());
    led_drive <= 8'(rnd());
    for (int i = 0; i < 8; i++) rd(8'(8'h10 + 4 * i), 32'(64 + i));
    rd(ctc_pkg::REG_PATTERN, 32'h0000_0000);
    rd(ctc_pkg::REG_MON_STATUS, 32'(sig_bus[71:64]));
    for (int i = 0; i < 8; i++)
    begin
      sel = (i == 0) ? 9'h1ff : (i == 1) ? 9'h000 : 9'(rnd());
      wr(8'(8'h10 + 4 * i), 32'(sel));
      exp_mon[i] = sig_bus[sel];
    end
    settle();
    `CHK(monitor_pin, exp_mon)
    rd(ctc_pkg::REG_MON_STATUS, 32'(exp_mon));
    rd(ctc_pkg::REG_INPUTS, 32'(opto_in));
    rd(ctc_pkg::REG_OUTPUTS, 32'(relay_drive));
    rd(ctc_pkg::REG_INDICATOR_STATE_VECTOR, 32'(led_drive));
    rd(8'hfc, 32'h0000_0000);
    $display("test status done");
    pat = rnd() & 32'h0000_ffff;
    wr(ctc_pkg::REG_PATTERN, pat);
    wr(ctc_pkg::REG_CONTACT_CMD, 32'(ctc_pkg::CTC_CT_APPLY));
    settle();
    `CHK(contact_out, relay_drive ^ pat[15:0])
    rd(ctc_pkg::REG_CONTACT_CMD, 32'h0000_0000);
    @(posedge sys_clk) logic_drive <= ~logic_drive;
    settle();
    `CHK(contact_out, relay_drive ^ pat[15:0])
    wr(ctc_pkg::REG_CONTACT_CMD, 32'(ctc_pkg::CTC_CT_REMOVE));
    settle();
    `CHK(contact_out, relay_drive)
    $display("test contacts done");
    wr(ctc_pkg::REG_IRQ_MASK, 32'h0000_0002);
    wr(ctc_pkg::REG_TEST_MODE, 32'(ctc_pkg::CTC_MODE_TEST));
    settle();
    `CHK({svc_off, irq, contact_out}, {2'b10, relay_drive})
    `CHK({alarm, oos, frz, cot_test}, 4'hf)
    rd(ctc_pkg::REG_OUTPUTS, 32'(relay_drive));
    wr(ctc_pkg::REG_TEST_MODE, 32'(ctc_pkg::CTC_MODE_BLOCKED));
    wr(ctc_pkg::REG_TEST_MODE, 32'h0000_0003);
    settle();
    `CHK(contact_out, 16'h0000)
    wr(ctc_pkg::REG_TEST_MODE, 32'(ctc_pkg::CTC_MODE_OFF));
    settle();
    `CHK({svc_off, contact_out}, {1'b0, relay_drive})
    `CHK({alarm, oos, frz, cot_test}, 4'h0)
    @(posedge sys_clk) test_mode_in <= 1'b1;
    settle();
    `CHK(svc_off, 1'b1)
    `CHK({alarm, oos, frz, cot_test}, 4'hf)
    @(posedge sys_clk) test_mode_in <= 1'b0;
    $display("test mode done");
    wr(ctc_pkg::REG_LAMP_CMD, 32'h0000_0001);
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK(indicator_out, 8'hff)
    rd(ctc_pkg::REG_LAMP_CMD, 32'h0000_0001);
    repeat (24) @(posedge sys_clk);
    rd(ctc_pkg::REG_LAMP_CMD, 32'h0000_0000);
    settle();
    `CHK({irq, indicator_out}, {1'b1, led_drive})
    wr(ctc_pkg::REG_IRQ_STATUS, 32'h0000_0007);
    settle();
    `CHK(irq, 1'b0)
    $display("test lamp done");
    @(posedge sys_clk) reclose_present <= 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      dly <= 3'(k * 5);
      wr(ctc_pkg::REG_RECLOSE_CMD, 32'h0000_0001);
      if (k == 1) rd(ctc_pkg::REG_RECLOSE_CMD, 32'h0000_0001);
      repeat (12) @(posedge sys_clk);
      rd(ctc_pkg::REG_RECLOSE_CMD, 32'h0000_0000);
    end
    settle();
    `CHK(n_trip, 2)
    rd(ctc_pkg::REG_IRQ_STATUS, 32'h0000_0004);
    $display("test reclose done");
    close_out();
  end
endmodule // tb_top
